// *** shared/rdp_pkg.sv ***
package rdp_pkg;

  // Tag values are not given here; defaults are parameters of the top
  localparam logic [7:0] LINK_TYPE_FWD_PTR = 8'h81;
  localparam logic [2:0] USAGE_COMBINED    = 3'h0;
  localparam logic [2:0] USAGE_SIG_ONLY    = 3'h1;
  localparam logic [2:0] USAGE_DATA_ONLY   = 3'h2;
  localparam logic [2:0] USAGE_RELEASE     = 3'h7;

  // Byte positions within the body (after the length byte)
  localparam logic [7:0] LNK_TYPE_POS   = 8'h06;
  localparam logic [7:0] LNK_NET_END    = 8'h08;
  localparam logic [7:0] LNK_CNT_POS    = 8'h09;
  localparam logic [7:0] FWD_FIXED_LEN  = 8'h10;
  localparam logic [1:0] PAIR_LAST_BYTE = 2'h3;

  // Register addresses of the plain register port
  localparam logic [3:0] ADDR_GROUP   = 4'h0;
  localparam logic [3:0] ADDR_CTRL    = 4'h1;
  localparam logic [3:0] ADDR_LINK0   = 4'h2;
  localparam logic [3:0] ADDR_LINK1   = 4'h3;
  localparam logic [3:0] ADDR_FWD0    = 4'h4;
  localparam logic [3:0] ADDR_FWD1    = 4'h5;
  localparam logic [3:0] ADDR_FWD2    = 4'h6;
  localparam logic [3:0] ADDR_FWD3    = 4'h7;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;

  typedef struct packed {
    logic [15:0] stream_id;
    logic [15:0] origin_net;
    logic [15:0] service_id;
    logic [15:0] return_network_label;
    logic        forward_signalling_pointer;
    logic        group_match;
  } rdp_link_s;

  typedef struct packed {
    logic [7:0]  spacecraft_number;
    logic [15:0] spot_number;
    logic [7:0]  control_centre_number;
    logic [2:0]  usage;
    logic [4:0]  operator_carrier_number;
    logic [31:0] frequency;
    logic [15:0] orbit_pos;
    logic        east;
    logic [1:0]  polarization;
    logic [4:0]  modulation;
    logic [23:0] symbol_rate;
    logic [3:0]  inner_code_rate;
  } rdp_fwd_s;

  typedef enum logic [2:0] {
    ST_TAG, ST_LEN, ST_LINK, ST_CONTENT, ST_FWD, ST_SKIP
  } rdp_state_e;

endpackage

// *** hw/rdp_group_match.sv ***
`timescale 1ns/10ps
// Base/mask range check: only bits with a clear mask bit must agree
module rdp_group_match #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] group_i,
  input  wire logic [W-1:0] pattern_i,
  input  wire logic [W-1:0] dontcare_i,
  output logic              match_o
);
  logic [W-1:0] bit_ok;

  // One comparator per bit position
  for (genvar b = 0; b < W; b++) begin : g_bit
    assign bit_ok[b] = dontcare_i[b] | (group_i[b] == pattern_i[b]);
  end

  assign match_o = &bit_ok;
endmodule

// *** hw/rdp_parser.sv ***
// Contract
// - Eight-bit tag picks which descriptor layout is decoded.
// - Eight-bit length bounds the descriptor and its trailing loops.
// - Reserved bits are skipped, their value never checked.
// - Linkage: capture stream, origin network and service identifiers.
// - Linkage type 0x81 marks a forward signalling pointer.
// - Capture sixteen-bit return network label after linkage type.
// - Range count plus one base/mask pairs are processed.
// - Group matches where all unmasked bits equal the pattern.
// - Terminal group number is a configured value set beforehand.
// - Linkage private bytes are skipped uninterpreted.
// - Content descriptor binds each listed table to one packet id.
// - Each eight-bit section kind entry is reported for that id.
// - Forward link descriptor replaces standard delivery descriptor.
// - Capture eight-bit spacecraft number.
// - Capture sixteen-bit spot number.
// - Capture eight-bit control centre number.
// - Extract three-bit usage code.
// - Usage 0 combined, 1 signalling, 2 data, 7 release.
// - Single-carrier terminal accepts only combined usage descriptors.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module rdp_parser #(
  parameter logic [7:0] TAG_LINKAGE = 8'h4a,
  parameter logic [7:0] TAG_CONTENT = 8'ha0,
  parameter logic [7:0] TAG_FWD     = 8'ha1
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        byte_valid_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        desc_start_i,
  input  wire logic [12:0] packet_id_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [31:0] reg_rdata_o,
  output rdp_pkg::rdp_link_s link_o,
  output logic             link_done_o,
  output rdp_pkg::rdp_fwd_s fwd_o,
  output logic             fwd_done_o,
  output logic             section_valid_o,
  output logic      [7:0]  section_kind_o,
  output logic      [12:0] section_pid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [15:0] group_q, group_d;
  logic        single_q, single_d;
  logic [31:0] rdata_q, rdata_d;

  // Group number is loaded by software before acquisition
  always_comb begin
    group_d  = group_q;
    single_d = single_q;
    if (reg_we_i && reg_addr_i == rdp_pkg::ADDR_GROUP) begin
      group_d = reg_wdata_i[15:0];
    end else if (reg_we_i && reg_addr_i == rdp_pkg::ADDR_CTRL) begin
      single_d = reg_wdata_i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parser state
  rdp_pkg::rdp_state_e st_q, st_d;
  rdp_pkg::rdp_state_e body_q, body_d; // Layout named by the tag
  logic [7:0]  len_q, len_d;     // Bytes left in body
  logic [7:0]  pos_q, pos_d;     // Body byte index
  logic [7:0]  pairs_q, pairs_d; // Pairs left minus one
  logic [1:0]  pb_q, pb_d;       // Byte within a pair
  logic        in_loop_q, in_loop_d;
  logic [31:0] pair_q, pair_d;
  logic [127:0] sh_q, sh_d;      // Forward fixed part, byte shifted
  rdp_pkg::rdp_link_s link_q, link_d;
  logic        link_done_q, link_done_d;
  rdp_pkg::rdp_fwd_s fwd_q, fwd_d;
  logic        fwd_done_q, fwd_done_d;
  logic        sec_v_q, sec_v_d;
  logic [7:0]  sec_k_q, sec_k_d;
  logic [12:0] pid_q, pid_d;
  logic        hit;
  logic        last;

  rdp_group_match #(
    .W (16)
  ) u_match (
    .group_i    (group_q),
    .pattern_i  (pair_q[23:8]),
    .dontcare_i ({pair_q[7:0], byte_i}),
    .match_o    (hit)
  );

  assign last = (len_q == 8'h01);

  // Byte walker; desc_start_i realigns onto a fresh tag at any time
  always_comb begin
    st_d        = st_q;
    body_d      = body_q;
    len_d       = len_q;
    pos_d       = pos_q;
    pairs_d     = pairs_q;
    pb_d        = pb_q;
    in_loop_d   = in_loop_q;
    pair_d      = pair_q;
    sh_d        = sh_q;
    link_d      = link_q;
    fwd_d       = fwd_q;
    pid_d       = pid_q;
    sec_k_d     = sec_k_q;
    link_done_d = 1'b0;
    fwd_done_d  = 1'b0;
    sec_v_d     = 1'b0;
    if (byte_valid_i) begin
      case (st_q)
        rdp_pkg::ST_TAG: begin
          // Unknown tags still walk their length and are dropped
          if (byte_i == TAG_LINKAGE) begin
            body_d = rdp_pkg::ST_LINK;
          end else if (byte_i == TAG_CONTENT) begin
            body_d = rdp_pkg::ST_CONTENT;
          end else if (byte_i == TAG_FWD) begin
            body_d = rdp_pkg::ST_FWD;
          end else begin
            body_d = rdp_pkg::ST_SKIP;
          end
          st_d    = rdp_pkg::ST_LEN; // Length byte follows next
          pos_d   = '0;
          pb_d    = '0;
          in_loop_d = 1'b0;
          pid_d   = packet_id_i;
          link_d  = '0;
        end
        rdp_pkg::ST_LEN: begin
          len_d = byte_i;
          if (byte_i == '0) begin
            st_d = rdp_pkg::ST_TAG;
          end else begin
            st_d = body_q;
          end
        end
        rdp_pkg::ST_LINK: begin
          pos_d = pos_q + 8'h01;
          if (pos_q < rdp_pkg::LNK_TYPE_POS) begin
            pair_d = {pair_q[23:0], byte_i};
            if (pos_q == 8'h01) link_d.stream_id  = {pair_q[7:0], byte_i};
            if (pos_q == 8'h03) link_d.origin_net = {pair_q[7:0], byte_i};
            if (pos_q == 8'h05) link_d.service_id = {pair_q[7:0], byte_i};
          end else if (pos_q == rdp_pkg::LNK_TYPE_POS) begin
            link_d.forward_signalling_pointer =
              (byte_i == rdp_pkg::LINK_TYPE_FWD_PTR);
          end else if (pos_q <= rdp_pkg::LNK_NET_END) begin
            pair_d = {pair_q[23:0], byte_i};
            if (pos_q == rdp_pkg::LNK_NET_END) begin
              link_d.return_network_label = {pair_q[7:0], byte_i};
            end
          end else if (pos_q == rdp_pkg::LNK_CNT_POS) begin
            pairs_d   = byte_i;
            in_loop_d = 1'b1;
            pb_d      = '0;
          end else if (in_loop_q) begin
            pair_d = {pair_q[23:0], byte_i};
            pb_d   = pb_q + 2'h1;
            if (pb_q == rdp_pkg::PAIR_LAST_BYTE) begin
              if (hit) link_d.group_match = 1'b1;
              if (pairs_q == '0) in_loop_d = 1'b0;
              pairs_d = pairs_q - 8'h01;
            end
          end
          // Remaining bytes are private data and are not looked at
          if (last) begin
            link_done_d = link_d.forward_signalling_pointer;
          end
        end
        rdp_pkg::ST_CONTENT: begin
          sec_v_d = 1'b1;
          sec_k_d = byte_i;
        end
        rdp_pkg::ST_FWD: begin
          pos_d = pos_q + 8'h01;
          if (pos_q < rdp_pkg::FWD_FIXED_LEN) begin
            sh_d = {sh_q[119:0], byte_i};
          end
          if (pos_q == rdp_pkg::FWD_FIXED_LEN - 8'h01) begin
            // Ignored links must not disturb the fields last accepted
            fwd_done_d = !single_q ||
                         (sh_d[95:93] == rdp_pkg::USAGE_COMBINED);
            if (fwd_done_d) begin
              // Low nibble is reserved and dropped unseen
              fwd_d = sh_d[127:4];
            end
          end
        end
        default: ; // ST_SKIP; trailing bytes of a forward link stay in ST_FWD
      endcase
      if (st_q != rdp_pkg::ST_TAG && st_q != rdp_pkg::ST_LEN) begin
        len_d = len_q - 8'h01;
        if (last) st_d = rdp_pkg::ST_TAG;
      end
    end
    if (desc_start_i) begin
      st_d = rdp_pkg::ST_TAG;
    end
  end

  // Read mux: captured fields and status
  always_comb begin
    rdata_d = '0;
    if (reg_re_i) begin
      if (reg_addr_i == rdp_pkg::ADDR_GROUP) begin
        rdata_d = {16'h0000, group_q};
      end else if (reg_addr_i == rdp_pkg::ADDR_CTRL) begin
        rdata_d = {31'h0, single_q};
      end else if (reg_addr_i == rdp_pkg::ADDR_LINK0) begin
        rdata_d = {link_q.stream_id, link_q.origin_net};
      end else if (reg_addr_i == rdp_pkg::ADDR_LINK1) begin
        rdata_d = {link_q.service_id, link_q.return_network_label};
      end else if (reg_addr_i == rdp_pkg::ADDR_FWD0) begin
        rdata_d = {fwd_q.spacecraft_number, fwd_q.spot_number,
                   fwd_q.control_centre_number};
      end else if (reg_addr_i == rdp_pkg::ADDR_FWD1) begin
        rdata_d = fwd_q.frequency;
      end else if (reg_addr_i == rdp_pkg::ADDR_FWD2) begin
        rdata_d = {fwd_q.orbit_pos, fwd_q.usage, fwd_q.operator_carrier_number,
                   fwd_q.east, fwd_q.polarization, fwd_q.modulation};
      end else if (reg_addr_i == rdp_pkg::ADDR_FWD3) begin
        rdata_d = {fwd_q.inner_code_rate, 4'h0, fwd_q.symbol_rate};
      end else if (reg_addr_i == rdp_pkg::ADDR_STATUS) begin
        rdata_d = {26'h0, st_q, link_q.forward_signalling_pointer,
                   link_q.group_match, 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      group_q     <= '0;
      single_q    <= 1'b0;
      rdata_q     <= '0;
      st_q        <= rdp_pkg::ST_TAG;
      body_q      <= rdp_pkg::ST_TAG;
      len_q       <= '0;
      pos_q       <= '0;
      pairs_q     <= '0;
      pb_q        <= '0;
      in_loop_q   <= 1'b0;
      pair_q      <= '0;
      sh_q        <= '0;
      link_q      <= '0;
      link_done_q <= 1'b0;
      fwd_q       <= '0;
      fwd_done_q  <= 1'b0;
      sec_v_q     <= 1'b0;
      sec_k_q     <= '0;
      pid_q       <= '0;
    end else begin
      group_q     <= group_d;
      single_q    <= single_d;
      rdata_q     <= rdata_d;
      st_q        <= st_d;
      body_q      <= body_d;
      len_q       <= len_d;
      pos_q       <= pos_d;
      pairs_q     <= pairs_d;
      pb_q        <= pb_d;
      in_loop_q   <= in_loop_d;
      pair_q      <= pair_d;
      sh_q        <= sh_d;
      link_q      <= link_d;
      link_done_q <= link_done_d;
      fwd_q       <= fwd_d;
      fwd_done_q  <= fwd_done_d;
      sec_v_q     <= sec_v_d;
      sec_k_q     <= sec_k_d;
      pid_q       <= pid_d;
    end
  end

  assign reg_rdata_o     = rdata_q;
  assign link_o          = link_q;
  assign link_done_o     = link_done_q;
  assign fwd_o           = fwd_q;
  assign fwd_done_o      = fwd_done_q;
  assign section_valid_o = sec_v_q;
  assign section_kind_o  = sec_k_q;
  assign section_pid_o   = pid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_section_pulse_kind: assert property (@(posedge clk_i) disable iff (!resetn_i)
    byte_valid_i && st_q == rdp_pkg::ST_CONTENT && !desc_start_i
    |=> section_valid_o && section_kind_o == $past(byte_i))
    else $error("Section kind entry not reported");
  a_single_usage: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fwd_done_o && single_q
    |-> fwd_o.usage == rdp_pkg::USAGE_COMBINED)
    else $error("Non-combined link accepted in single mode");
  a_link_type_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
    link_done_o |-> link_o.forward_signalling_pointer)
    else $error("Linkage done without pointer type");
  a_tag_to_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
    byte_valid_i && st_q == rdp_pkg::ST_TAG && !desc_start_i
    |=> st_q == rdp_pkg::ST_LEN)
    else $error("Tag byte not followed by length");
  a_len_bounds: assert property (@(posedge clk_i) disable iff (!resetn_i)
    byte_valid_i && len_q == 8'h01 && st_q != rdp_pkg::ST_TAG
    && st_q != rdp_pkg::ST_LEN |=> st_q == rdp_pkg::ST_TAG)
    else $error("Descriptor overran its length");
  a_group_cfg: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reg_we_i && reg_addr_i == rdp_pkg::ADDR_GROUP
    |=> group_q == $past(reg_wdata_i[15:0]))
    else $error("Group number not loaded");
  a_pid_bind: assert property (@(posedge clk_i) disable iff (!resetn_i)
    byte_valid_i && st_q == rdp_pkg::ST_TAG && !desc_start_i
    |=> section_pid_o == $past(packet_id_i))
    else $error("Section kind bound to wrong packet id");
  a_fwd_rate_field: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fwd_done_o |-> fwd_o.inner_code_rate == $past(byte_i[7:4]))
    else $error("Inner code rate misplaced");
endmodule

// *** tb/rdp_byte_source.sv ***
`timescale 1ns/10ps
// Section demultiplexer model: hands descriptor bytes to the parser
module rdp_byte_source (
  input  wire logic       clk_i,
  output logic            valid_o,
  output logic      [7:0] data_o
);
  // Quiet bus at start
  initial begin
    valid_o = 1'b0;
    data_o  = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // Idle cycle: data toggles so a stale byte is never mistaken for a new one
  task automatic idle();
    @(posedge clk_i);
    valid_o <= 1'b0;
    data_o  <= ~data_o;
  endtask

  // One byte, after gap idle cycles; gap 0 streams bytes back to back
  task automatic put(input logic [7:0] b, input int gap);
    repeat (gap) idle();
    @(posedge clk_i);
    valid_o <= 1'b1;
    data_o  <= b;
  endtask
endmodule

// *** tb/test_rcs_descriptor_parser.sv ***
`timescale 1ns/10ps
module test_rcs_descriptor_parser;
  localparam logic [7:0] TAG_LNK = 8'h4a;
  localparam logic [7:0] TAG_CNT = 8'ha0;
  localparam logic [7:0] TAG_FWD = 8'ha1;
  logic              clk_i;
  logic              resetn_i;
  logic              desc_start_i;
  logic              reg_we_i;
  logic              reg_re_i;
  logic       [12:0] packet_id_i;
  logic        [3:0] reg_addr_i;
  logic       [31:0] reg_wdata_i;
  logic       [31:0] reg_rdata_o;
  logic              byte_valid_i;
  logic        [7:0] byte_i;
  rdp_pkg::rdp_link_s link_o;
  rdp_pkg::rdp_fwd_s  fwd_o;
  logic              link_done_o;
  logic              fwd_done_o;
  logic              section_valid_o;
  logic        [7:0] section_kind_o;
  logic       [12:0] section_pid_o;
  int                mismatches;
  int                num_checks;
  int                n_link;
  int                n_fwd;
  logic       [20:0] sec_q[$];

  rdp_parser dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .byte_valid_i(byte_valid_i), .byte_i(byte_i),
    .desc_start_i(desc_start_i), .packet_id_i(packet_id_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .link_o(link_o), .link_done_o(link_done_o), .fwd_o(fwd_o),
    .fwd_done_o(fwd_done_o), .section_valid_o(section_valid_o),
    .section_kind_o(section_kind_o), .section_pid_o(section_pid_o));

  rdp_byte_source src (.clk_i(clk_i), .valid_o(byte_valid_i),
    .data_o(byte_i));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Pulse monitor: pulses last one cycle, so they are counted at every edge
  always @(posedge clk_i) begin
    if (link_done_o === 1'b1) n_link++;
    if (fwd_done_o === 1'b1) n_fwd++;
    if (section_valid_o === 1'b1) sec_q.push_back({section_pid_o,
                                                   section_kind_o});
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Tag, length, body; the length is always the true body size
  task automatic send(input logic [7:0] tag, input logic [7:0] b[$],
                      input int gap);
    src.put(tag, gap);
    src.put(8'(b.size()), gap);
    foreach (b[i]) src.put(b[i], gap);
    src.idle();
    repeat (3) @(posedge clk_i);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    rd(rdp_pkg::ADDR_CTRL, d);
    chk(d, 32'h0);
    wr(rdp_pkg::ADDR_GROUP, 32'h0000_1234);
    rd(rdp_pkg::ADDR_GROUP, d);
    chk(d, 32'h0000_1234);
    rd(4'hf, d);
    chk(d, 32'h0);
  endtask

  // Two ranges, the second matching only through its dont-care bits
  task automatic t_link();
    logic [31:0] d;
    send(TAG_LNK, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h81,
      8'h77, 8'h88, 8'h01, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h12, 8'h00,
      8'h00, 8'hff, 8'hab}, 0);
    chk(n_link, 1);
    chk(link_o, {16'h1122, 16'h3344, 16'h5566, 16'h7788, 2'b11});
    rd(rdp_pkg::ADDR_LINK0, d);
    chk(d, 32'h1122_3344);
    rd(rdp_pkg::ADDR_LINK1, d);
    chk(d, 32'h5566_7788);
    send(TAG_LNK, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h81,
      8'h77, 8'h88, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00}, 1);
    chk(n_link, 2);
    chk(link_o.group_match, 1'b0);
    send(TAG_LNK, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h80,
      8'h77, 8'h88, 8'h00, 8'h12, 8'h34, 8'h00, 8'h00}, 0);
    chk(n_link, 2);
    rd(rdp_pkg::ADDR_STATUS, d);
    chk(d, {26'h0, rdp_pkg::ST_TAG, 1'b0, 1'b1, 1'b0});
  endtask

  // Aborted forward descriptor, unknown tag, then a slow content list
  task automatic t_content();
    src.put(TAG_FWD, 0);
    src.put(8'h13, 0);
    src.put(8'h21, 0);
    src.idle();
    desc_start_i <= 1'b1;
    @(posedge clk_i);
    desc_start_i <= 1'b0;
    send(8'h55, '{TAG_CNT, 8'h01}, 0);
    packet_id_i <= 13'h1abc;
    send(TAG_CNT, '{8'h41, 8'h42, 8'h43}, 2);
    chk(sec_q.size(), 3);
    foreach (sec_q[i]) chk(sec_q[i], {13'h1abc, 8'h41 + 8'(i)});
  endtask

  // Every usage code in single-carrier mode, then release in multi mode
  task automatic t_fwd();
    rdp_pkg::rdp_fwd_s e;
    logic        [2:0] u[5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h7};
    logic       [31:0] d;
    int                n;
    wr(rdp_pkg::ADDR_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr(rdp_pkg::ADDR_CTRL, 32'h0);
      n = n_fwd;
      e = '{8'h21, 16'h3456, 8'h78, u[i], 5'h05, 32'h1122_3344, 16'h0192,
            1'b1, 2'h2, 5'h01, 24'h1b7740, 4'h2};
      // Reserved nibble changes each time, as the sender may do
      send(TAG_FWD, '{8'h21, 8'h34, 8'h56, 8'h78, {u[i], 5'h05}, 8'h11,
        8'h22, 8'h33, 8'h44, 8'h01, 8'h92, 8'hc1, 8'h1b, 8'h77, 8'h40,
        {4'h2, 4'(i * 7 + 3)}, 8'hde, 8'had, 8'hbe}, i % 2);
      chk(n_fwd - n, (u[i] == 3'h0 || i == 4));
      if (n_fwd != n) begin
        chk(fwd_o, e);
      end else begin
        chk(fwd_o.usage, 3'h0);
      end
    end
    rd(rdp_pkg::ADDR_FWD1, d);
    chk(d, 32'h1122_3344);
    rd(rdp_pkg::ADDR_FWD0, d);
    chk(d, 32'h2134_5678);
    rd(rdp_pkg::ADDR_FWD2, d);
    chk(d, 32'h0192_e5c1);
    rd(rdp_pkg::ADDR_FWD3, d);
    chk(d, 32'h201b_7740);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence; reset held for ten cycles
  initial begin
    resetn_i     = 1'b0;
    desc_start_i = 1'b0;
    reg_we_i     = 1'b0;
    reg_re_i     = 1'b0;
    packet_id_i  = 13'h0;
    reg_addr_i   = 4'h0;
    reg_wdata_i  = 32'h0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_link();
    t_content();
    t_fwd();
    wrap_up();
  end

  // Watchdog: the whole run needs well under 2000 cycles
  initial begin
    #40000;
    mismatches++;
    wrap_up();
  end
endmodule
